// [hw/gds_consts.vh]
// register map, field positions and timing counts of the gate supply supervisor
`ifndef GDS_CONSTS_VH
`define GDS_CONSTS_VH

// register byte addresses
`define GDS_ADDR_CTRL        8'h00
`define GDS_ADDR_STATUS      8'h04
`define GDS_ADDR_INT_STAT    8'h08
`define GDS_ADDR_INT_MASK    8'h0C
`define GDS_ADDR_EVT_COUNT   8'h10

// control fields
`define GDS_CTRL_CLEAR_BIT   0
`define GDS_CTRL_CHECK_OFF   1

// status fields
`define GDS_ST_FAULT         0
`define GDS_ST_SUPPLY_LOW    1
`define GDS_ST_DRIVE_LOW     2
`define GDS_ST_LIVE_MOTOR    8
`define GDS_ST_LIVE_DRAIN    9
`define GDS_ST_LIVE_PUMP     10
`define GDS_ST_LIVE_LOWSIDE  11

// interrupt fields
`define GDS_INT_SUPPLY       0
`define GDS_INT_DRIVE        1
`define GDS_INT_WIDTH        2

// reset values
`define GDS_CHECK_OFF_RST    1'b0
`define GDS_INT_MASK_RST     2'h0

// enable reset pulse window
`define GDS_CLK_MHZ          25
`define GDS_RST_MIN_NS       8000
`define GDS_RST_MAX_NS       40000
`define GDS_RST_MIN_CYC      ((`GDS_RST_MIN_NS * `GDS_CLK_MHZ + 999) / 1000)
`define GDS_RST_MAX_CYC      ((`GDS_RST_MAX_NS * `GDS_CLK_MHZ) / 1000)

`endif

// [hw/gds_sync.v]
// two flip-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/100ps
module gds_sync #(
    parameter WIDTH = 5
) (
    // clock and reset
    input  wire             i_clock,
    input  wire             i_reset,
    // levels
    input  wire [WIDTH-1:0] i_async,
    output wire [WIDTH-1:0] o_sync
);

genvar g;
generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
        reg stage_a;
        reg stage_b;
        // first stage is read by the second stage only
        always @(posedge i_clock)
        begin
            if (i_reset)
            begin
                stage_a <= 1'b0;
                stage_b <= 1'b0;
            end
            else
            begin
                stage_a <= i_async[g];
                stage_b <= stage_a;
            end
        end
        assign o_sync[g] = stage_b;
    end
endgenerate

endmodule

// [hw/gds_pulse_clear.v]
// measures low pulses on the enable input and flags a reset-length pulse
`timescale 1ns/100ps
module gds_pulse_clear #(
    parameter [15:0] MIN_CYC = 16'h00C8,
    parameter [15:0] MAX_CYC = 16'h03E8
) (
    // clock and reset
    input  wire i_clock,
    input  wire i_reset,
    // synchronised enable level
    input  wire i_enable,
    // one-cycle clear request
    output reg  o_clear
);

reg [15:0] low_count;
reg        enable_prev;

always @(posedge i_clock)
begin
    if (i_reset)
    begin
        // start saturated: the synchroniser reads low while it flushes after reset,
        // and that must never count as a clear pulse
        low_count   <= 16'hFFFF;
        enable_prev <= 1'b1;
        o_clear     <= 1'b0;
    end
    else
    begin
        enable_prev <= i_enable;
        o_clear     <= 1'b0;
        if (!i_enable)
        begin
            // saturate so a long sleep never wraps into the window
            if (low_count != 16'hFFFF)
                low_count <= low_count + 16'h0001;
        end
        else
        begin
            low_count <= 16'h0000;
            if (!enable_prev && low_count >= MIN_CYC && low_count <= MAX_CYC)
                o_clear <= 1'b1;
        end
    end
end

endmodule

// [hw/gds_supervisor.v]
// undervoltage supervisor for a three-phase gate driver, with apb register slave
// How it works
// - motor or drain undervoltage blocks gates, stops pump, drives alarm low
// - motor or drain undervoltage latches global fault and supply low flag
// - when supply undervoltage goes away, gates and alarm recover by themselves
// - supply low flag holds until clear command or enable reset pulse
// - pump or low-side supply undervoltage blocks gates and drives alarm low
// - drive supply undervoltage latches global fault and drive supply flag
// - when drive supply undervoltage clears, gates and alarm recover by themselves
// - drive supply flag holds until clear command or enable reset pulse
// - with check-off bit set, drive supply undervoltage only shows in the live status bits
// - without registers, drive supply checking is always on
// - supply and drive supply flags are set independently, may be set together
`timescale 1ns/100ps
`include "gds_consts.vh"
module gds_supervisor #(
    parameter        HAS_REGS    = 1,
    parameter [15:0] RST_MIN_CYC = `GDS_RST_MIN_CYC,
    parameter [15:0] RST_MAX_CYC = `GDS_RST_MAX_CYC
) (
    // clock and reset
    input  wire        i_clock,
    input  wire        i_reset,
    // apb slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [7:0]  i_paddr,
    input  wire [31:0] i_pwdata,
    input  wire [3:0]  i_pstrb,
    output reg  [31:0] o_prdata,
    output wire        o_pready,
    output wire        o_pslverr,
    // comparator levels, high means below threshold
    input  wire        i_motor_supply_pin_low,
    input  wire        i_drain_sense_pin_low,
    input  wire        i_pump_output_pin_low,
    input  wire        i_lowside_supply_pin_low,
    // enable pin
    input  wire        i_enable,
    // driver controls
    output reg         o_gate_enable,
    output reg         o_pump_enable,
    output reg         o_alarm_indicator_n,
    // interrupt
    output reg         o_irq
);

// decodes one register address
function addr_is;
    input [7:0] addr;
    input [7:0] target;
    begin
        addr_is = (addr[7:2] == target[7:2]);
    end
endfunction

// synchronised pins
wire [4:0] pins_sync;
wire       motor_low;
wire       drain_low;
wire       pump_low;
wire       lowside_low;
wire       enable_sync;

gds_sync #(
    .WIDTH (5)
) u_sync (
    .i_clock (i_clock),
    .i_reset (i_reset),
    .i_async ({i_enable, i_lowside_supply_pin_low, i_pump_output_pin_low,
               i_drain_sense_pin_low, i_motor_supply_pin_low}),
    .o_sync  (pins_sync)
);

assign motor_low   = pins_sync[0];
assign drain_low   = pins_sync[1];
assign pump_low    = pins_sync[2];
assign lowside_low = pins_sync[3];
assign enable_sync = pins_sync[4];

// enable reset pulse detector
wire pulse_clear;

gds_pulse_clear #(
    .MIN_CYC (RST_MIN_CYC),
    .MAX_CYC (RST_MAX_CYC)
) u_pulse (
    .i_clock  (i_clock),
    .i_reset  (i_reset),
    .i_enable (enable_sync),
    .o_clear  (pulse_clear)
);

// apb phases
wire access   = i_psel & i_penable;
wire setup    = i_psel & ~i_penable;
wire wr_acc   = access & i_pwrite;
wire lane0_wr = wr_acc & i_pstrb[0];

wire mapped = addr_is(i_paddr, `GDS_ADDR_CTRL)
            | addr_is(i_paddr, `GDS_ADDR_STATUS)
            | addr_is(i_paddr, `GDS_ADDR_INT_STAT)
            | addr_is(i_paddr, `GDS_ADDR_INT_MASK)
            | addr_is(i_paddr, `GDS_ADDR_EVT_COUNT);

// no wait states: read data is captured during setup
assign o_pready  = access;
assign o_pslverr = access & ~mapped;

// registers
reg                     check_off;
reg                     fault_flag;
reg                     supply_flag;
reg                     drive_flag;
reg [`GDS_INT_WIDTH-1:0] int_stat;
reg [`GDS_INT_WIDTH-1:0] int_mask;
reg [7:0]               supply_events;
reg [7:0]               drive_events;
reg                     supply_low_prev;
reg                     drive_low_prev;

// conditions
wire supply_low;
wire drive_check_on;
wire drive_low;
wire any_low;
wire clear_cmd;
wire clear_all;
wire supply_rise;
wire drive_rise;

assign supply_low = motor_low | drain_low;
// pin-configured build cannot switch the check off
assign drive_check_on = (HAS_REGS == 0) ? 1'b1 : ~check_off;
assign drive_low = (pump_low | lowside_low) & drive_check_on;
assign any_low = supply_low | drive_low;

// command is a write strobe only, no storage behind it
assign clear_cmd = lane0_wr & addr_is(i_paddr, `GDS_ADDR_CTRL)
                 & i_pwdata[`GDS_CTRL_CLEAR_BIT];
assign clear_all = clear_cmd | pulse_clear;

assign supply_rise = supply_low & ~supply_low_prev;
assign drive_rise  = drive_low & ~drive_low_prev;

// next values of latched flags: a present condition wins over a clear
reg next_fault_flag;
reg next_supply_flag;
reg next_drive_flag;

always @*
begin
    next_supply_flag = supply_low | (supply_flag & ~clear_all);
    next_drive_flag  = drive_low | (drive_flag & ~clear_all);
    next_fault_flag  = any_low | (fault_flag & ~clear_all);
end

always @(posedge i_clock)
begin
    if (i_reset)
    begin
        fault_flag  <= 1'b0;
        supply_flag <= 1'b0;
        drive_flag  <= 1'b0;
    end
    else
    begin
        fault_flag  <= next_fault_flag;
        supply_flag <= next_supply_flag;
        drive_flag  <= next_drive_flag;
    end
end

// protective outputs follow the live conditions, no clear needed to recover
always @(posedge i_clock)
begin
    if (i_reset)
    begin
        o_gate_enable       <= 1'b0;
        o_pump_enable       <= 1'b0;
        o_alarm_indicator_n <= 1'b1;
    end
    else
    begin
        o_gate_enable       <= ~any_low;
        o_pump_enable       <= ~supply_low;
        o_alarm_indicator_n <= ~any_low;
    end
end

// control register
always @(posedge i_clock)
begin
    if (i_reset)
        check_off <= `GDS_CHECK_OFF_RST;
    else if (lane0_wr && addr_is(i_paddr, `GDS_ADDR_CTRL) && HAS_REGS != 0)
        check_off <= i_pwdata[`GDS_CTRL_CHECK_OFF];
end

// interrupt status, write one to clear, new event wins
reg [`GDS_INT_WIDTH-1:0] int_events;
reg [`GDS_INT_WIDTH-1:0] int_w1c;
reg [`GDS_INT_WIDTH-1:0] next_int_stat;

always @*
begin
    int_events = {drive_rise, supply_rise};
    int_w1c    = {`GDS_INT_WIDTH{1'b0}};
    if (lane0_wr && addr_is(i_paddr, `GDS_ADDR_INT_STAT))
        int_w1c = i_pwdata[`GDS_INT_WIDTH-1:0];
    next_int_stat = (int_stat & ~int_w1c) | int_events;
end

always @(posedge i_clock)
begin
    if (i_reset)
    begin
        int_stat        <= {`GDS_INT_WIDTH{1'b0}};
        int_mask        <= `GDS_INT_MASK_RST;
        supply_low_prev <= 1'b0;
        drive_low_prev  <= 1'b0;
        o_irq           <= 1'b0;
    end
    else
    begin
        int_stat        <= next_int_stat;
        supply_low_prev <= supply_low;
        drive_low_prev  <= drive_low;
        if (lane0_wr && addr_is(i_paddr, `GDS_ADDR_INT_MASK))
            int_mask <= i_pwdata[`GDS_INT_WIDTH-1:0];
        // one cycle behind status, acceptable for a level interrupt
        o_irq <= |(int_stat & int_mask);
    end
end

// saturating onset counters, cleared together with the flags
reg [7:0] next_supply_events;
reg [7:0] next_drive_events;

always @*
begin
    next_supply_events = clear_all ? 8'h00 : supply_events;
    if (supply_rise && next_supply_events != 8'hFF)
        next_supply_events = next_supply_events + 8'h01;
    next_drive_events = clear_all ? 8'h00 : drive_events;
    if (drive_rise && next_drive_events != 8'hFF)
        next_drive_events = next_drive_events + 8'h01;
end

always @(posedge i_clock)
begin
    if (i_reset)
    begin
        supply_events <= 8'h00;
        drive_events  <= 8'h00;
    end
    else
    begin
        supply_events <= next_supply_events;
        drive_events  <= next_drive_events;
    end
end

// read mux
reg [31:0] read_value;

always @*
begin
    read_value = 32'h00000000;
    if (addr_is(i_paddr, `GDS_ADDR_CTRL))
    begin
        // clear bit always reads zero
        read_value[`GDS_CTRL_CHECK_OFF] = check_off;
    end
    else if (addr_is(i_paddr, `GDS_ADDR_STATUS))
    begin
        read_value[`GDS_ST_FAULT]        = fault_flag;
        read_value[`GDS_ST_SUPPLY_LOW]   = supply_flag;
        read_value[`GDS_ST_DRIVE_LOW]    = drive_flag;
        read_value[`GDS_ST_LIVE_MOTOR]   = motor_low;
        read_value[`GDS_ST_LIVE_DRAIN]   = drain_low;
        read_value[`GDS_ST_LIVE_PUMP]    = pump_low;
        read_value[`GDS_ST_LIVE_LOWSIDE] = lowside_low;
    end
    else if (addr_is(i_paddr, `GDS_ADDR_INT_STAT))
    begin
        read_value[`GDS_INT_WIDTH-1:0] = int_stat;
    end
    else if (addr_is(i_paddr, `GDS_ADDR_INT_MASK))
    begin
        read_value[`GDS_INT_WIDTH-1:0] = int_mask;
    end
    else if (addr_is(i_paddr, `GDS_ADDR_EVT_COUNT))
    begin
        read_value[15:0] = {drive_events, supply_events};
    end
end

// capture in setup so data is stable from a flop through the access phase
always @(posedge i_clock)
begin
    if (i_reset)
        o_prdata <= 32'h00000000;
    else if (setup && !i_pwrite)
        o_prdata <= read_value;
end

endmodule

// [test/gds_supervisor_asserts.sv]
// port-level assertions for the gate supply supervisor
`timescale 1ns/100ps
module gds_sv_asserts (
    // clock and reset
    input wire       i_clock,
    input wire       i_reset,
    // apb
    input wire       i_psel,
    input wire       i_penable,
    input wire [7:0] i_paddr,
    input wire       o_pready,
    input wire       o_pslverr,
    // comparators
    input wire       i_motor_supply_pin_low,
    input wire       i_drain_sense_pin_low,
    input wire       i_pump_output_pin_low,
    input wire       i_lowside_supply_pin_low,
    // driver controls
    input wire       o_gate_enable,
    input wire       o_pump_enable,
    input wire       o_alarm_indicator_n
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    wire sup_low = i_motor_supply_pin_low | i_drain_sense_pin_low;
    wire any_low = sup_low | i_pump_output_pin_low | i_lowside_supply_pin_low;
    // three edges: two sync flops plus the output flop
    supply_block_a: assert property (
        sup_low [*3] |=> !o_gate_enable && !o_pump_enable && !o_alarm_indicator_n)
        else $error("supply undervoltage did not block outputs");
    all_recover_a: assert property (
        !any_low [*3] |=> o_gate_enable && o_pump_enable && o_alarm_indicator_n)
        else $error("outputs did not recover");
    pump_run_a: assert property (
        !sup_low [*3] |=> o_pump_enable)
        else $error("pump stopped without supply undervoltage");
    alarm_gate_a: assert property (
        !$past(i_reset) |-> o_gate_enable == o_alarm_indicator_n)
        else $error("alarm and gate enable disagree");
    pump_gate_a: assert property (
        !$past(i_reset) && !o_pump_enable |-> !o_gate_enable)
        else $error("gates on while pump stopped");
    apb_ready_a: assert property (i_psel && i_penable |-> o_pready)
        else $error("no ready in access phase");
    apb_idle_a: assert property (!(i_psel && i_penable) |-> !o_pready && !o_pslverr)
        else $error("ready or error outside access phase");
    apb_slverr_a: assert property (i_psel && i_penable |-> o_pslverr == (i_paddr > 8'h13))
        else $error("wrong error response");
endmodule

bind gds_supervisor gds_sv_asserts i_gds_sv_asserts (
    .i_clock(i_clock), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_paddr(i_paddr), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_motor_supply_pin_low(i_motor_supply_pin_low),
    .i_drain_sense_pin_low(i_drain_sense_pin_low),
    .i_pump_output_pin_low(i_pump_output_pin_low),
    .i_lowside_supply_pin_low(i_lowside_supply_pin_low),
    .o_gate_enable(o_gate_enable), .o_pump_enable(o_pump_enable),
    .o_alarm_indicator_n(o_alarm_indicator_n));

// [test/gds_ctl_model.sv]
// controller side model: drives the enable pin and its reset pulses
`timescale 1ns/100ps
module gds_ctl_model (
    // clock
    input  wire       i_clock,
    // pulse request and length in cycles
    input  wire       i_go,
    input  wire [7:0] i_len,
    // enable pin
    output logic      o_enable = 1'b1
);
    logic [7:0] cnt = 8'h00;
    always @(posedge i_clock)
    begin
        if (i_go)
            cnt <= i_len;
        else if (cnt != 8'h00)
            cnt <= cnt - 8'h01;
        o_enable <= !(i_go || cnt > 8'h01);
    end
endmodule

// [test/tb.sv]
// self-checking bench for the gate supply supervisor
`timescale 1ns/100ps
module tb;
    logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go = 1'b0;
    logic        pready, gate, pump, alarm_n, irq, en, gate_fixed;
    logic [7:0]  addr = 8'h00;
    logic [3:0]  pins = 4'h0;
    logic [31:0] wd = 32'h0, rdat, lf = 32'h65B0;
    logic [31:0] q[$];
    int          error_cnt = 0, cmp_count = 0, cyc = 0;
    always #20 clk = ~clk;
    gds_ctl_model i_gds_ctl_model (.i_clock(clk), .i_go(go), .i_len(8'h08), .o_enable(en));
    // short enable pulse window keeps the run brief
    gds_supervisor #(.RST_MIN_CYC(16'h0004), .RST_MAX_CYC(16'h0014)) i_gds_supervisor (
        .i_clock(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(addr), .i_pwdata(wd), .i_pstrb(4'hF), .o_prdata(rdat), .o_pready(pready),
        .o_pslverr(), .i_motor_supply_pin_low(pins[3]), .i_drain_sense_pin_low(pins[2]),
        .i_pump_output_pin_low(pins[1]), .i_lowside_supply_pin_low(pins[0]), .i_enable(en),
        .o_gate_enable(gate), .o_pump_enable(pump), .o_alarm_indicator_n(alarm_n), .o_irq(irq));
    // pin-configured build: the drive supply check cannot be switched off
    gds_supervisor #(.HAS_REGS(0), .RST_MIN_CYC(16'h0004), .RST_MAX_CYC(16'h0014))
        i_gds_supervisor_fixed (
        .i_clock(clk), .i_reset(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(addr), .i_pwdata(wd), .i_pstrb(4'hF), .o_prdata(), .o_pready(),
        .o_pslverr(), .i_motor_supply_pin_low(pins[3]), .i_drain_sense_pin_low(pins[2]),
        .i_pump_output_pin_low(pins[1]), .i_lowside_supply_pin_low(pins[0]), .i_enable(en),
        .o_gate_enable(gate_fixed), .o_pump_enable(), .o_alarm_indicator_n(), .o_irq());
    function logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // reads note their expected word; the monitor below compares it
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wd <= d;
        if (!w)
            q.push_back(d);
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task pin(input logic [3:0] p);
        @(posedge clk);
        pins <= p;
        repeat (5) @(posedge clk);
    endtask
    task chk(input logic [3:0] e);
        cmp({28'h0, gate, pump, alarm_n, irq}, {28'h0, e});
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (psel && pen && !pwr && pready)
            cmp(rdat, q.size() != 0 ? q.pop_front() : 32'hDEAD_BEEF);
        if (cyc == 4000)
        begin
            error_cnt++;
            test_done;
        end
    end
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        pin(4'h0);
        chk(4'hE);
        xfer(1'b0, 8'h00, 32'h0);
        xfer(1'b0, 8'h04, 32'h0);
        xfer(1'b0, 8'h20, 32'h0);
        lf = lfsr(lf);
        xfer(1'b1, 8'h0C, lf);
        xfer(1'b0, 8'h0C, lf & 32'h3);
        xfer(1'b1, 8'h0C, 32'h0);
        $display("test reset done");
        pin(4'h8);
        chk(4'h0);
        xfer(1'b0, 8'h04, 32'h103);
        pin(4'h0);
        chk(4'hE);
        xfer(1'b0, 8'h04, 32'h3);
        xfer(1'b0, 8'h10, 32'h1);
        xfer(1'b1, 8'h0C, 32'h1);
        repeat (3) @(posedge clk);
        chk(4'hF);
        xfer(1'b1, 8'h08, 32'h1);
        repeat (3) @(posedge clk);
        chk(4'hE);
        xfer(1'b1, 8'h0C, 32'h0);
        xfer(1'b1, 8'h00, 32'h1);
        xfer(1'b0, 8'h04, 32'h0);
        xfer(1'b0, 8'h00, 32'h0);
        $display("test supply done");
        pin(4'h6);
        chk(4'h0);
        xfer(1'b0, 8'h04, 32'h607);
        xfer(1'b0, 8'h10, 32'h101);
        pin(4'h2);
        chk(4'h4);
        xfer(1'b0, 8'h04, 32'h407);
        xfer(1'b1, 8'h00, 32'h1);
        xfer(1'b0, 8'h04, 32'h405);
        xfer(1'b0, 8'h10, 32'h0);
        pin(4'h0);
        chk(4'hE);
        xfer(1'b0, 8'h04, 32'h5);
        @(posedge clk);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (20) @(posedge clk);
        xfer(1'b0, 8'h04, 32'h0);
        $display("test drive done");
        xfer(1'b1, 8'h00, 32'h2);
        pin(4'h1);
        chk(4'hE);
        cmp({31'h0, gate_fixed}, 32'h0);
        xfer(1'b0, 8'h04, 32'h800);
        xfer(1'b0, 8'h00, 32'h2);
        pin(4'h0);
        cmp({31'h0, gate_fixed}, 32'h1);
        $display("test check off done");
        test_done;
    end
endmodule
